// >>> core/ccmu_pkg.sv
// Shared constants and types of the capture/compare/PWM channel
package ccmu_pkg;
	// Register byte offsets on the Avalon-MM slave
	localparam logic [4:0] OFFS_CHANNEL_CONTROL     = 5'h00;
	localparam logic [4:0] OFFS_CAPTURE_VALUE_LOW   = 5'h04;
	localparam logic [4:0] OFFS_CAPTURE_VALUE_HIGH  = 5'h08;
	localparam logic [4:0] OFFS_CHANNEL_STATUS      = 5'h0C;
	localparam logic [4:0] OFFS_TIMER_SELECT        = 5'h10;

	// Field positions
	localparam int         POS_DUTY_LOW_BITS        = 4;
	localparam int         POS_EVENT_FLAG           = 0;
	localparam int         POS_IRQ_ENABLE           = 1;

	// Values after reset
	localparam logic [3:0]  RESET_MODE              = 4'h0;
	localparam logic [1:0]  RESET_DUTY_LOW          = 2'h0;
	localparam logic [15:0] RESET_VALUE             = 16'h0000;
	localparam logic [1:0]  RESET_TIMER_SELECT      = 2'h0;
	localparam logic [3:0]  RESET_PRESCALE          = 4'h0;
	localparam logic [31:0] READ_ZERO               = 32'h0000_0000;

	// Channel mode select codes
	localparam logic [3:0] MODE_OFF                 = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE          = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL            = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE            = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4           = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16          = 4'h7;
	localparam logic [3:0] MODE_CMP_SET_HIGH        = 4'h8;
	localparam logic [3:0] MODE_CMP_SET_LOW         = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT            = 4'hA;
	localparam logic [3:0] MODE_CMP_SPECIAL         = 4'hB;
	localparam logic [1:0] FAMILY_CAPTURE           = 2'h1;
	localparam logic [1:0] FAMILY_COMPARE           = 2'h2;
	localparam logic [1:0] FAMILY_PWM               = 2'h3;

	// Prescaler terminal counts (edges minus one)
	localparam logic [3:0] PRESCALE_LAST_4          = 4'h3;
	localparam logic [3:0] PRESCALE_LAST_16         = 4'hF;

	// Timer assignment configurations
	localparam logic [1:0] TSEL_ALL_FIRST           = 2'h0;
	localparam logic [1:0] TSEL_ONE_KEEPS_FIRST     = 2'h1;
	localparam logic [1:0] TSEL_TWO_KEEP_FIRST      = 2'h2;
	localparam logic [1:0] TSEL_ALL_THIRD           = 2'h3;

	// Bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} ccmu_bus_type;

	// Whole state of the channel
	typedef struct packed {
		ccmu_bus_type bus_state;
		logic         waitreq;
		logic [31:0]  rdata;
		logic [3:0]   mode;
		logic [1:0]   duty_low;
		logic [15:0]  value;
		logic         flag;
		logic         irq_en;
		logic [1:0]   tsel;
		logic         pin_sync1;
		logic         pin_sync2;
		logic         pin_prev;
		logic [3:0]   presc;
		logic         match_prev;
		logic         pin_latch;
		logic         pin_oe;
		logic         special;
		logic         rst_first;
		logic         rst_third;
		logic         irq;
		logic         use_third;
		logic [9:0]   duty;
	} ccmu_state_type;
endpackage

// >>> core/ccmu_channel.sv
// Capture/compare/PWM channel with Avalon-MM register slave
`timescale 1ns/1ps
module ccmu_channel #(
	parameter int CHANNEL_INDEX = 3
) (
	// Clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RST_IN,
	// Avalon-MM slave
	input  wire logic [4:0]  AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	input  wire logic [3:0]  AVS_BYTEENABLE_IN,
	output logic      [31:0] AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	// Shared timers
	input  wire logic [15:0] FIRST_TIMER_COUNT_IN,
	input  wire logic [15:0] THIRD_TIMER_COUNT_IN,
	output logic             FIRST_TIMER_RESET_OUT,
	output logic             THIRD_TIMER_RESET_OUT,
	output logic             USE_THIRD_TIMER_OUT,
	// Module pin
	input  wire logic        MODULE_PIN_IN,
	output logic             MODULE_PIN_OUT,
	output logic             MODULE_PIN_OE_OUT,
	// Channel events and PWM duty
	output logic             SPECIAL_EVENT_OUT,
	output logic             CHANNEL_EVENT_FLAG_OUT,
	output logic             CHANNEL_IRQ_OUT,
	output logic      [9:0]  PWM_DUTY_OUT
);

	ccmu_pkg::ccmu_state_type r;
	ccmu_pkg::ccmu_state_type n;

	// Outputs straight from the state flops
	assign AVS_READDATA_OUT       = r.rdata;
	assign AVS_WAITREQUEST_OUT    = r.waitreq;
	assign FIRST_TIMER_RESET_OUT  = r.rst_first;
	assign THIRD_TIMER_RESET_OUT  = r.rst_third;
	assign USE_THIRD_TIMER_OUT    = r.use_third;
	assign MODULE_PIN_OUT         = r.pin_latch;
	assign MODULE_PIN_OE_OUT      = r.pin_oe;
	assign SPECIAL_EVENT_OUT      = r.special;
	assign CHANNEL_EVENT_FLAG_OUT = r.flag;
	assign CHANNEL_IRQ_OUT        = r.irq;
	assign PWM_DUTY_OUT           = r.duty;

	// Next-state logic of the whole channel
	always_comb begin
		logic        rise;
		logic        fall;
		logic        cap_event;
		logic        is_capture;
		logic        is_compare;
		logic        match;
		logic        match_edge;
		logic        use_third;
		logic [15:0] cur_timer;
		logic [31:0] rd_mux;
		logic        req;
		logic        wr_now;
		logic [3:0]  new_mode;
		logic        lane0;
		rise       = 1'b0;
		fall       = 1'b0;
		cap_event  = 1'b0;
		is_capture = 1'b0;
		is_compare = 1'b0;
		match      = 1'b0;
		match_edge = 1'b0;
		use_third  = 1'b0;
		cur_timer  = 16'h0000;
		rd_mux     = ccmu_pkg::READ_ZERO;
		req        = 1'b0;
		wr_now     = 1'b0;
		new_mode   = 4'h0;
		lane0      = 1'b0;
		n          = r;

		// One-cycle strobes fall back each cycle
		n.special   = 1'b0;
		n.rst_first = 1'b0;
		n.rst_third = 1'b0;

		// Two-flop synchroniser, third flop for edges
		n.pin_sync1 = MODULE_PIN_IN;
		n.pin_sync2 = r.pin_sync1;
		n.pin_prev  = r.pin_sync2;
		rise        = r.pin_sync2 & ~r.pin_prev;
		fall        = ~r.pin_sync2 & r.pin_prev;

		// Timer pair chosen by configuration and channel position
		case (r.tsel)
			ccmu_pkg::TSEL_ALL_FIRST:       use_third = 1'b0;
			ccmu_pkg::TSEL_ONE_KEEPS_FIRST: use_third = (CHANNEL_INDEX != 0);
			ccmu_pkg::TSEL_TWO_KEEP_FIRST:  use_third = (CHANNEL_INDEX > 1);
			ccmu_pkg::TSEL_ALL_THIRD:       use_third = 1'b1;
			default:                        use_third = 1'b0;
		endcase
		n.use_third = use_third;
		cur_timer   = use_third ? THIRD_TIMER_COUNT_IN : FIRST_TIMER_COUNT_IN;

		// Mode family decode
		is_capture = (r.mode[3:2] == ccmu_pkg::FAMILY_CAPTURE);
		is_compare = (r.mode == ccmu_pkg::MODE_CMP_TOGGLE) ||
			(r.mode[3:2] == ccmu_pkg::FAMILY_COMPARE);

		// Capture edge detector and prescaler
		case (r.mode)
			ccmu_pkg::MODE_CAP_FALL: begin
				cap_event = fall;
			end
			ccmu_pkg::MODE_CAP_RISE: begin
				cap_event = rise;
			end
			ccmu_pkg::MODE_CAP_RISE4: begin
				if (rise) begin
					if (r.presc >= ccmu_pkg::PRESCALE_LAST_4) begin
						cap_event = 1'b1;
						n.presc   = ccmu_pkg::RESET_PRESCALE;
					end else begin
						n.presc = r.presc + 4'h1;
					end
				end
			end
			ccmu_pkg::MODE_CAP_RISE16: begin
				if (rise) begin
					if (r.presc == ccmu_pkg::PRESCALE_LAST_16) begin
						cap_event = 1'b1;
						n.presc   = ccmu_pkg::RESET_PRESCALE;
					end else begin
						n.presc = r.presc + 4'h1;
					end
				end
			end
			default: begin
				cap_event = 1'b0;
			end
		endcase
		if (!is_capture) begin
			n.presc = ccmu_pkg::RESET_PRESCALE;
		end

		// Compare match acts once per equality
		match        = is_compare && (r.value == cur_timer);
		match_edge   = match & ~r.match_prev;
		n.match_prev = match;

		// Avalon-MM handshake: one wait cycle, then the answer
		req    = AVS_READ_IN | AVS_WRITE_IN;
		lane0  = AVS_BYTEENABLE_IN[0];
		case (AVS_ADDRESS_IN)
			ccmu_pkg::OFFS_CHANNEL_CONTROL:
				rd_mux = {24'h00_0000, 2'b00, r.duty_low, r.mode};
			ccmu_pkg::OFFS_CAPTURE_VALUE_LOW:
				rd_mux = {24'h00_0000, r.value[7:0]};
			ccmu_pkg::OFFS_CAPTURE_VALUE_HIGH:
				rd_mux = {24'h00_0000, r.value[15:8]};
			ccmu_pkg::OFFS_CHANNEL_STATUS:
				rd_mux = {30'h000_0000, r.irq_en, r.flag};
			ccmu_pkg::OFFS_TIMER_SELECT:
				rd_mux = {30'h000_0000, r.tsel};
			default:
				rd_mux = ccmu_pkg::READ_ZERO;
		endcase
		case (r.bus_state)
			ccmu_pkg::BUS_IDLE: begin
				if (req) begin
					n.bus_state = ccmu_pkg::BUS_ACK;
					n.waitreq   = 1'b0;
					n.rdata     = AVS_READ_IN ? rd_mux : ccmu_pkg::READ_ZERO;
				end
			end
			ccmu_pkg::BUS_ACK: begin
				n.bus_state = ccmu_pkg::BUS_IDLE;
				n.waitreq   = 1'b1;
				wr_now      = AVS_WRITE_IN & lane0;
			end
			default: begin
				n.bus_state = ccmu_pkg::BUS_IDLE;
				n.waitreq   = 1'b1;
			end
		endcase

		// Register writes take effect at the answering edge
		if (wr_now) begin
			case (AVS_ADDRESS_IN)
				ccmu_pkg::OFFS_CHANNEL_CONTROL: begin
					new_mode   = AVS_WRITEDATA_IN[3:0];
					n.mode     = new_mode;
					n.duty_low = AVS_WRITEDATA_IN[ccmu_pkg::POS_DUTY_LOW_BITS +: 2];
					if (new_mode == ccmu_pkg::MODE_OFF) begin
						n.pin_latch  = 1'b0;
						n.presc      = ccmu_pkg::RESET_PRESCALE;
						n.match_prev = 1'b0;
					end else if (new_mode != r.mode) begin
						if (new_mode == ccmu_pkg::MODE_CMP_SET_HIGH) begin
							n.pin_latch = 1'b0;
						end else if (new_mode == ccmu_pkg::MODE_CMP_SET_LOW) begin
							n.pin_latch = 1'b1;
						end
					end
					// Prescale-to-prescale switch leaves the count alone
				end
				ccmu_pkg::OFFS_CAPTURE_VALUE_LOW: begin
					n.value[7:0] = AVS_WRITEDATA_IN[7:0];
				end
				ccmu_pkg::OFFS_CAPTURE_VALUE_HIGH: begin
					n.value[15:8] = AVS_WRITEDATA_IN[7:0];
				end
				ccmu_pkg::OFFS_CHANNEL_STATUS: begin
					n.flag   = AVS_WRITEDATA_IN[ccmu_pkg::POS_EVENT_FLAG];
					n.irq_en = AVS_WRITEDATA_IN[ccmu_pkg::POS_IRQ_ENABLE];
				end
				ccmu_pkg::OFFS_TIMER_SELECT: begin
					n.tsel = AVS_WRITEDATA_IN[1:0];
				end
				default: begin
					n.tsel = n.tsel;
				end
			endcase
		end

		// Capture wins over a coincident software write
		if (cap_event) begin
			n.value = cur_timer;
			n.flag  = 1'b1;
		end

		// Compare match actions; setting beats a coincident clear
		if (match_edge) begin
			n.flag = 1'b1;
			case (r.mode)
				ccmu_pkg::MODE_CMP_TOGGLE:   n.pin_latch = ~r.pin_latch;
				ccmu_pkg::MODE_CMP_SET_HIGH: n.pin_latch = 1'b1;
				ccmu_pkg::MODE_CMP_SET_LOW:  n.pin_latch = 1'b0;
				ccmu_pkg::MODE_CMP_SOFT:     n.pin_latch = r.pin_latch;
				ccmu_pkg::MODE_CMP_SPECIAL: begin
					n.special   = 1'b1;
					n.rst_first = ~use_third;
					n.rst_third = use_third;
				end
				default:                     n.pin_latch = r.pin_latch;
			endcase
		end

		// Off mode keeps the compare latch low
		if (n.mode == ccmu_pkg::MODE_OFF) begin
			n.pin_latch = 1'b0;
		end

		// Pin is driven only by the output-changing compare modes
		n.pin_oe = (n.mode == ccmu_pkg::MODE_CMP_TOGGLE) ||
			(n.mode == ccmu_pkg::MODE_CMP_SET_HIGH) ||
			(n.mode == ccmu_pkg::MODE_CMP_SET_LOW);

		// Interrupt request and PWM duty word
		n.irq  = n.flag & n.irq_en;
		n.duty = (n.mode[3:2] == ccmu_pkg::FAMILY_PWM) ?
			{n.value[7:0], n.duty_low} : 10'h000;
	end

	// State register with synchronous reset
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			r           <= '0;
			r.bus_state <= ccmu_pkg::BUS_IDLE;
			r.waitreq   <= 1'b1;
			r.mode      <= ccmu_pkg::RESET_MODE;
			r.duty_low  <= ccmu_pkg::RESET_DUTY_LOW;
			r.value     <= ccmu_pkg::RESET_VALUE;
			r.tsel      <= ccmu_pkg::RESET_TIMER_SELECT;
			r.presc     <= ccmu_pkg::RESET_PRESCALE;
		end else begin
			r <= n;
		end
	end

endmodule

// >>> tb/ccmu_far_side.sv
// Model of the shared timers and the module pin wire
`timescale 1ns/1ps
module ccmu_far_side (
	// Clock, reset and bench controls
	input	wire logic		clk_in,
	input	wire logic		rst_in,
	input	wire logic		run_in,
	input	wire logic		level_in,
	// Channel side
	input	wire logic		first_reset_in,
	input	wire logic		third_reset_in,
	input	wire logic		pin_out_in,
	input	wire logic		pin_oe_in,
	output	logic	[15:0]	first_count_out,
	output	logic	[15:0]	third_count_out,
	output	logic			pin_level_out
);
	// Timers count on the system clock; a trigger pulse clears the one it names
	always_ff @(posedge clk_in) begin
		if (rst_in || first_reset_in)
			first_count_out <= 16'h0000;
		else if (run_in)
			first_count_out <= first_count_out + 16'h0001;
		if (rst_in || third_reset_in)
			third_count_out <= 16'h0000;
		else if (run_in)
			third_count_out <= third_count_out + 16'h0003;
	end
	// Wire level: the channel wins while it drives
	assign pin_level_out = pin_oe_in ? pin_out_in : level_in;
endmodule

// >>> tb/ccmu_channel_properties.sv
// Port checks of the capture/compare channel
`timescale 1ns/1ps
module ccmu_channel_properties (
	// Clock, reset and bus
	input	wire logic			CLK_IN,
	input	wire logic			RST_IN,
	input	wire logic			AVS_READ_IN,
	input	wire logic			AVS_WRITE_IN,
	input	wire logic			AVS_WAITREQUEST_OUT,
	// Channel outputs
	input	wire logic			FIRST_TIMER_RESET_OUT,
	input	wire logic			THIRD_TIMER_RESET_OUT,
	input	wire logic			USE_THIRD_TIMER_OUT,
	input	wire logic			MODULE_PIN_OE_OUT,
	input	wire logic			SPECIAL_EVENT_OUT,
	input	wire logic			CHANNEL_EVENT_FLAG_OUT,
	input	wire logic			CHANNEL_IRQ_OUT,
	input	wire logic	[9:0]	PWM_DUTY_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	// Bus handshake
	take_answer_a: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
		|=> !AVS_WAITREQUEST_OUT) else $error("request not answered");
	ack_single_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
		else $error("answer too long");
	// Event flag and interrupt
	flag_sticky_a: assert property (CHANNEL_EVENT_FLAG_OUT && !AVS_WRITE_IN
		|=> CHANNEL_EVENT_FLAG_OUT) else $error("flag dropped");
	irq_flag_a: assert property (CHANNEL_IRQ_OUT |-> CHANNEL_EVENT_FLAG_OUT)
		else $error("irq without flag");
	// Special trigger
	special_timer_a: assert property (SPECIAL_EVENT_OUT |-> (USE_THIRD_TIMER_OUT ?
		THIRD_TIMER_RESET_OUT : FIRST_TIMER_RESET_OUT)) else $error("timer not cleared");
	special_pin_a: assert property (SPECIAL_EVENT_OUT |-> !MODULE_PIN_OE_OUT ##1
		(!SPECIAL_EVENT_OUT && CHANNEL_EVENT_FLAG_OUT)) else $error("special misbehaves");
	// Duty only in pwm, state after reset
	duty_pwm_a: assert property (MODULE_PIN_OE_OUT |-> PWM_DUTY_OUT == 10'h000)
		else $error("duty outside pwm");
	reset_state_a: assert property ($fell(RST_IN) |-> AVS_WAITREQUEST_OUT
		&& !CHANNEL_EVENT_FLAG_OUT && !MODULE_PIN_OE_OUT) else $error("bad reset state");
	// Main scenarios
	cover property (SPECIAL_EVENT_OUT);
	cover property ($rose(CHANNEL_EVENT_FLAG_OUT));
	cover property (CHANNEL_IRQ_OUT);
endmodule
bind ccmu_channel ccmu_channel_properties chk (.CLK_IN, .RST_IN, .AVS_READ_IN, .AVS_WRITE_IN,
	.AVS_WAITREQUEST_OUT, .FIRST_TIMER_RESET_OUT, .THIRD_TIMER_RESET_OUT, .USE_THIRD_TIMER_OUT,
	.MODULE_PIN_OE_OUT, .SPECIAL_EVENT_OUT, .CHANNEL_EVENT_FLAG_OUT, .CHANNEL_IRQ_OUT,
	.PWM_DUTY_OUT);

// >>> tb/tb.sv
// Bench of the capture/compare channel
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] zero = 32'h0000_0000;
	logic			CLK_IN = 1'b0, RST_IN = 1'b1, AVS_READ_IN = 1'b0, AVS_WRITE_IN = 1'b0;
	logic			run = 1'b0, level = 1'b0;
	logic	[4:0]	AVS_ADDRESS_IN = 5'h00;
	logic	[3:0]	AVS_BYTEENABLE_IN = 4'hF;
	logic	[31:0]	AVS_WRITEDATA_IN = zero, AVS_READDATA_OUT, seen;
	logic			AVS_WAITREQUEST_OUT, FIRST_TIMER_RESET_OUT, THIRD_TIMER_RESET_OUT;
	logic			USE_THIRD_TIMER_OUT, MODULE_PIN_IN, MODULE_PIN_OUT, MODULE_PIN_OE_OUT;
	logic			SPECIAL_EVENT_OUT, CHANNEL_EVENT_FLAG_OUT, CHANNEL_IRQ_OUT;
	logic	[15:0]	FIRST_TIMER_COUNT_IN, THIRD_TIMER_COUNT_IN, e;
	logic	[9:0]	PWM_DUTY_OUT;
	logic	[3:0]	modes [5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
	logic	[2:0]	tab [5] = '{3'h5, 3'h5, 3'h3, 3'h0, 3'h0};
	int				fail_count = 0, checks_done = 0, cycles = 0, spec_seen = 0, spec_base = 0;
	// Design and far side
	ccmu_channel uut (
		.CLK_IN(CLK_IN), .RST_IN(RST_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
		.AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
		.AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
		.AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
		.FIRST_TIMER_COUNT_IN(FIRST_TIMER_COUNT_IN), .THIRD_TIMER_COUNT_IN(THIRD_TIMER_COUNT_IN),
		.FIRST_TIMER_RESET_OUT(FIRST_TIMER_RESET_OUT),
		.THIRD_TIMER_RESET_OUT(THIRD_TIMER_RESET_OUT),
		.USE_THIRD_TIMER_OUT(USE_THIRD_TIMER_OUT), .MODULE_PIN_IN(MODULE_PIN_IN),
		.MODULE_PIN_OUT(MODULE_PIN_OUT), .MODULE_PIN_OE_OUT(MODULE_PIN_OE_OUT),
		.SPECIAL_EVENT_OUT(SPECIAL_EVENT_OUT), .CHANNEL_EVENT_FLAG_OUT(CHANNEL_EVENT_FLAG_OUT),
		.CHANNEL_IRQ_OUT(CHANNEL_IRQ_OUT), .PWM_DUTY_OUT(PWM_DUTY_OUT));
	ccmu_far_side far (.clk_in(CLK_IN), .rst_in(RST_IN), .run_in(run), .level_in(level),
		.first_reset_in(FIRST_TIMER_RESET_OUT), .third_reset_in(THIRD_TIMER_RESET_OUT),
		.pin_out_in(MODULE_PIN_OUT), .pin_oe_in(MODULE_PIN_OE_OUT),
		.first_count_out(FIRST_TIMER_COUNT_IN), .third_count_out(THIRD_TIMER_COUNT_IN),
		.pin_level_out(MODULE_PIN_IN));
	// Clock
	always #10 CLK_IN = ~CLK_IN;
	// Trigger pulse count and hang limit
	always @(posedge CLK_IN) begin
		cycles++;
		spec_seen += 32'(SPECIAL_EVENT_OUT === 1'b1);
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end
	// Compare and count
	task automatic chk(string what, logic [31:0] s, logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, x, s);
		end
	endtask
	// One transfer, held until waitrequest is sampled low
	task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
		@(posedge CLK_IN);
		AVS_ADDRESS_IN <= a;
		AVS_WRITEDATA_IN <= d;
		AVS_WRITE_IN <= w;
		AVS_READ_IN <= !w;
		do @(posedge CLK_IN); while (AVS_WAITREQUEST_OUT !== 1'b0);
		seen = AVS_READDATA_OUT;
		AVS_WRITE_IN <= 1'b0;
		AVS_READ_IN <= 1'b0;
	endtask
	task automatic rchk(string what, logic [4:0] a, logic [31:0] x);
		bus(1'b0, a, zero);
		chk(what, seen, x);
	endtask
	// Timers run n cycles, then hold
	task automatic tick(int n);
		run <= 1'b1;
		repeat (n) @(posedge CLK_IN);
		run <= 1'b0;
		@(posedge CLK_IN);
	endtask
	// n pulses on the pin, then time for the synchroniser
	task automatic edges(int n);
		repeat (n) begin
			level <= 1'b1;
			repeat (4) @(posedge CLK_IN);
			level <= 1'b0;
			repeat (4) @(posedge CLK_IN);
		end
		repeat (6) @(posedge CLK_IN);
	endtask
	// Capture mode m: pre pulses give nothing, the next one captures
	task automatic capt(logic [3:0] m, int pre, logic third = 1'b0);
		bus(1'b1, 5'h00, zero);
		bus(1'b1, 5'h00, {28'h000_0000, m});
		bus(1'b1, 5'h0C, zero);
		edges(pre);
		rchk("early flag", 5'h0C, zero);
		tick(7);
		e = third ? THIRD_TIMER_COUNT_IN : FIRST_TIMER_COUNT_IN;
		edges(1);
		rchk("flag", 5'h0C, 32'h0000_0001);
		rchk("low", 5'h04, {24'h00_0000, e[7:0]});
		rchk("high", 5'h08, {24'h00_0000, e[15:8]});
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		for (int a = 0; a < 6; a++)
			rchk("reset", 5'(4 * a), zero);
		bus(1'b1, 5'h00, 32'h0000_00FF);
		rchk("control", 5'h00, 32'h0000_003F);
		bus(1'b1, 5'h04, 32'h0000_00A5);
		bus(1'b1, 5'h08, 32'h0000_005A);
		rchk("low", 5'h04, 32'h0000_00A5);
		rchk("high", 5'h08, 32'h0000_005A);
		AVS_BYTEENABLE_IN <= 4'hE;
		bus(1'b1, 5'h04, 32'h0000_0011);
		AVS_BYTEENABLE_IN <= 4'hF;
		rchk("lane off", 5'h04, 32'h0000_00A5);
		chk("duty", 32'(PWM_DUTY_OUT), 32'h0000_0297);
		bus(1'b1, 5'h00, 32'h0000_0035);
		bus(1'b1, 5'h14, 32'h0000_00FF);
		rchk("unmapped", 5'h14, zero);
		chk("duty off", 32'(PWM_DUTY_OUT), zero);
		for (int t = 0; t < 4; t++) begin
			bus(1'b1, 5'h10, 32'(t));
			rchk("select", 5'h10, 32'(t));
			chk("third", 32'(USE_THIRD_TIMER_OUT), 32'(t != 0));
		end
		capt(4'h5, 0, 1'b1);
		bus(1'b1, 5'h10, zero);
		capt(4'h5, 0);
		tick(5);
		e = FIRST_TIMER_COUNT_IN;
		edges(1);
		rchk("overwrite", 5'h04, {24'h00_0000, e[7:0]});
		capt(4'h4, 0);
		capt(4'h6, 3);
		capt(4'h7, 15);
		// Direct prescale switch keeps the edge count
		bus(1'b1, 5'h00, zero);
		bus(1'b1, 5'h00, 32'h0000_0006);
		bus(1'b1, 5'h0C, zero);
		edges(2);
		bus(1'b1, 5'h00, 32'h0000_0007);
		edges(13);
		rchk("kept count", 5'h0C, zero);
		edges(1);
		rchk("switched", 5'h0C, 32'h0000_0001);
		// Compare modes: drive, entry level, match action
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, 5'h00, zero);
			bus(1'b1, 5'h0C, zero);
			chk("cleared pin", 32'(MODULE_PIN_OUT), zero);
			e = FIRST_TIMER_COUNT_IN + 16'h0014;
			bus(1'b1, 5'h04, {24'h00_0000, e[7:0]});
			bus(1'b1, 5'h08, {24'h00_0000, e[15:8]});
			bus(1'b1, 5'h00, {28'h000_0000, modes[i]});
			spec_base = spec_seen;
			repeat (2) @(posedge CLK_IN);
			chk("drive", 32'(MODULE_PIN_OE_OUT), 32'(tab[i][0]));
			chk("entry", 32'(MODULE_PIN_OUT), 32'(tab[i][1]));
			run <= 1'b1;
			for (int n = 0; n < 100 && CHANNEL_EVENT_FLAG_OUT !== 1'b1; n++)
				@(posedge CLK_IN);
			run <= 1'b0;
			repeat (3) @(posedge CLK_IN);
			chk("match flag", 32'(CHANNEL_EVENT_FLAG_OUT), 32'h0000_0001);
			chk("after", 32'(MODULE_PIN_OUT), 32'(tab[i][2]));
			chk("special", spec_seen - spec_base, 32'(modes[i] == 4'hB));
		end
		chk("timer reset", 32'(FIRST_TIMER_COUNT_IN), zero);
		bus(1'b1, 5'h0C, 32'h0000_0003);
		repeat (2) @(posedge CLK_IN);
		chk("irq", 32'(CHANNEL_IRQ_OUT), 32'h0000_0001);
		bus(1'b1, 5'h0C, 32'h0000_0002);
		repeat (2) @(posedge CLK_IN);
		chk("irq off", 32'(CHANNEL_IRQ_OUT), zero);
		summarize();
	end
endmodule
